// ==== include/hbr_defs.svh ====
`ifndef HBR_DEFS_SVH
`define HBR_DEFS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define HBR_IDX_W 8
`define HBR_ADDR_LSB 2
`define HBR_IDX_RX_DATA 8'h05
`define HBR_IDX_TX_STAT 8'h06
`define HBR_IDX_CODE_CTRL 8'h07
`define HBR_IDX_TX_DATA 8'h08
`define HBR_IDX_TX_END 8'h09
`define HBR_IDX_IRQ_STAT 8'h0A
`define HBR_IDX_IRQ_MASK 8'h0B

// ==========================================================================
// Field positions
`define HBR_TXS_VACANT 2
`define HBR_TXS_NO_ROOM 1
`define HBR_TXS_STARVED 0
`define HBR_CC_TRIGGER 7
`define HBR_CC_SOURCE 6
`define HBR_CODE_MSB 5
`define HBR_CODE_LSB 0
`define HBR_IRQ_STARVED 0
`define HBR_IRQ_RX_DATA 1
`define HBR_IRQ_TX_VACANT 2
`define HBR_ENTRY_LAST 8

// ==========================================================================
// Reset values and constants
`define HBR_CODE_CTRL_RST 8'h00
`define HBR_IRQ_RST 3'h0
`define HBR_CODE_LAST_IDX 3'd5
`define HBR_BYTE_BITS 4'd8
`define HBR_STUFF_LIMIT 3'd5
`define HBR_FLAG_BYTE 8'h7E
`define HBR_ABORT_BYTE 8'hFF
`define HBR_FIFO_DEPTH 64
`define HBR_FIFO_AW 6
`define HBR_HTRANS_ACTIVE 1
`define HBR_HRESP_OKAY 1'b0
`define HBR_UPPER_ZERO 22'h000000

`endif

// ==== include/hbr_pkg.sv ====
package hbr_pkg;

  typedef logic [7:0] hbr_byte_t;
  typedef logic [8:0] hbr_entry_t;
  typedef logic [2:0] hbr_irq_t;

  typedef enum logic [1:0] {
    HBR_TX_FLAG,
    HBR_TX_DATA,
    HBR_TX_ABORT
  } hbr_tx_state_t;

endpackage : hbr_pkg

// ==== include/hbr_fifo_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface hbr_fifo_if;
  import hbr_pkg::*;
  logic push_valid;
  logic push_ready;
  hbr_entry_t push_data;
  logic pop_valid;
  logic pop_ready;
  hbr_entry_t pop_data;
  logic full;
  logic empty;

  modport store (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data, full, empty
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data, full, empty
  );
endinterface : hbr_fifo_if

`default_nettype wire

// ==== logic/hbr_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hbr_defs.svh"

module hbr_fifo (
  input wire logic hclk,
  input wire logic hresetn,
  hbr_fifo_if.store q
);
  import hbr_pkg::*;

  hbr_entry_t mem [`HBR_FIFO_DEPTH];
  logic [`HBR_FIFO_AW:0] wr_ptr_r;
  logic [`HBR_FIFO_AW:0] rd_ptr_r;

  // ========================================================================
  // Pointers carry one extra wrap bit so full and empty differ
  wire ptr_same = wr_ptr_r[`HBR_FIFO_AW-1:0] == rd_ptr_r[`HBR_FIFO_AW-1:0];
  wire wrap_diff = wr_ptr_r[`HBR_FIFO_AW] != rd_ptr_r[`HBR_FIFO_AW];
  wire do_push = q.push_valid & q.push_ready;
  wire do_pop = q.pop_valid & q.pop_ready;

  assign q.empty = ptr_same & ~wrap_diff;
  assign q.full = ptr_same & wrap_diff;
  assign q.push_ready = ~q.full;
  assign q.pop_valid = ~q.empty;
  assign q.pop_data = mem[rd_ptr_r[`HBR_FIFO_AW-1:0]];

  always_ff @(posedge hclk)
  begin
    if (do_push)
      mem[wr_ptr_r[`HBR_FIFO_AW-1:0]] <= q.push_data;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

endmodule : hbr_fifo

`default_nettype wire

// ==== logic/hbr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hbr_defs.svh"

// Overview of operation
// - Transmit status bit 2 is live high while transmit FIFO is empty.
// - Transmit status bit 1 is live high while transmit FIFO is full.
// - FIFO empty mid-packet sends abort and sets underrun flag in bit 0.
// - Underrun flag is sticky; only a transmit status read clears it.
// - Transmit status bits 7 to 3 are unassigned; host ignores them.
// - Rising edge of send-code bit 7 starts sending the six-bit code.
// - Bit 6 low takes link bits from external pin; high, onboard.
// - Code goes out code bit 0 first, code bit 5 last.
module hbr_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_byte_valid,
  input wire hbr_pkg::hbr_byte_t rx_byte,
  output logic rx_byte_ready,
  input wire logic link_bit_tick,
  input wire logic external_link_data_input,
  output logic data_link_out,
  output logic irq
);
  import hbr_pkg::*;

  // ========================================================================
  // FIFOs
  hbr_fifo_if txq ();
  hbr_fifo_if rxq ();

  hbr_fifo u_tx_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .q(txq)
  );

  hbr_fifo u_rx_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .q(rxq)
  );

  // ========================================================================
  // Register state
  hbr_byte_t code_ctrl_r;
  logic starved_r;
  logic starved_nxt;
  hbr_irq_t irq_stat_r;
  hbr_irq_t irq_stat_nxt;
  hbr_irq_t irq_mask_r;
  logic [31:0] hrdata_r;
  logic wr_pend_r;
  logic [`HBR_IDX_W-1:0] wr_idx_r;
  logic vacant_d_r;

  // ========================================================================
  // Link state
  logic ext_meta_r;
  logic ext_sync_r;
  hbr_tx_state_t state_r;
  hbr_tx_state_t state_nxt;
  hbr_byte_t shift_r;
  logic [3:0] bit_cnt_r;
  logic [2:0] ones_r;
  logic stuff_on_r;
  logic cur_last_r;
  logic code_active_r;
  logic [2:0] code_idx_r;
  logic link_out_r;

  // ========================================================================
  // AHB-Lite decode
  wire ahb_take = hsel & hready & htrans[`HBR_HTRANS_ACTIVE];
  wire [`HBR_IDX_W-1:0] a_idx = haddr[`HBR_ADDR_LSB +: `HBR_IDX_W];
  wire a_aligned = haddr[1:0] == 2'h0;
  wire a_upper_ok = haddr[31:10] == `HBR_UPPER_ZERO;
  wire a_ok = a_aligned & a_upper_ok;
  wire rd_take = ahb_take & ~hwrite & a_ok;
  wire wr_take = ahb_take & hwrite & a_ok;

  wire rd_rx_data = rd_take & (a_idx == `HBR_IDX_RX_DATA);
  wire rd_tx_stat = rd_take & (a_idx == `HBR_IDX_TX_STAT);
  wire rd_irq_stat = rd_take & (a_idx == `HBR_IDX_IRQ_STAT);

  wire wr_code = wr_pend_r & (wr_idx_r == `HBR_IDX_CODE_CTRL);
  wire wr_tx_data = wr_pend_r & (wr_idx_r == `HBR_IDX_TX_DATA);
  wire wr_tx_end = wr_pend_r & (wr_idx_r == `HBR_IDX_TX_END);
  wire wr_mask = wr_pend_r & (wr_idx_r == `HBR_IDX_IRQ_MASK);

  assign hreadyout = 1'b1;
  assign hresp = `HBR_HRESP_OKAY;
  assign hrdata = hrdata_r;

  // ========================================================================
  // Read data mux
  hbr_byte_t tx_stat_val;
  hbr_byte_t rx_data_val;
  hbr_byte_t rd_val;

  always_comb
  begin
    tx_stat_val = 8'h00;
    tx_stat_val[`HBR_TXS_VACANT] = txq.empty;
    tx_stat_val[`HBR_TXS_NO_ROOM] = txq.full;
    tx_stat_val[`HBR_TXS_STARVED] = starved_r;
  end

  // Empty FIFO reads back zero rather than stale memory
  assign rx_data_val = rxq.pop_valid ? rxq.pop_data[7:0] : 8'h00;

  always_comb
  begin
    unique case (a_idx)
      `HBR_IDX_RX_DATA: rd_val = rx_data_val;
      `HBR_IDX_TX_STAT: rd_val = tx_stat_val;
      `HBR_IDX_CODE_CTRL: rd_val = code_ctrl_r;
      `HBR_IDX_IRQ_STAT: rd_val = {5'h00, irq_stat_r};
      `HBR_IDX_IRQ_MASK: rd_val = {5'h00, irq_mask_r};
      default: rd_val = 8'h00;
    endcase
  end

  // Read side effects happen in the address phase, so the data
  // phase can return the value with no wait state.
  assign rxq.pop_ready = rd_rx_data;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h00000000;
    else if (rd_take)
      hrdata_r <= {24'h000000, rd_val};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= '0;
    end
    else
    begin
      wr_pend_r <= wr_take;
      wr_idx_r <= a_idx;
    end
  end

  // ========================================================================
  // Transmit FIFO fill and receive FIFO feed
  // A write into a full FIFO is dropped; software checks the full flag.
  assign txq.push_valid = wr_tx_data | wr_tx_end;
  assign txq.push_data = {wr_tx_end, hwdata[7:0]};

  assign rxq.push_valid = rx_byte_valid;
  assign rxq.push_data = {1'b0, rx_byte};
  assign rx_byte_ready = rxq.push_ready;

  // ========================================================================
  // Control registers
  wire code_rise = wr_code & hwdata[`HBR_CC_TRIGGER]
                   & ~code_ctrl_r[`HBR_CC_TRIGGER];
  wire code_trig = code_ctrl_r[`HBR_CC_TRIGGER];
  wire onboard_link_source_select = code_ctrl_r[`HBR_CC_SOURCE];
  wire [5:0] code_word = code_ctrl_r[`HBR_CODE_MSB:`HBR_CODE_LSB];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      code_ctrl_r <= `HBR_CODE_CTRL_RST;
    else if (wr_code)
      code_ctrl_r <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_mask_r <= `HBR_IRQ_RST;
    else if (wr_mask)
      irq_mask_r <= hwdata[2:0];
  end

  // ========================================================================
  // External link pin synchroniser
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
    end
    else
    begin
      ext_meta_r <= external_link_data_input;
      ext_sync_r <= ext_meta_r;
    end
  end

  // ========================================================================
  // HDLC serialiser: flags while idle, none between back-to-back packets; zero stuffing in packets
  // No frame check sequence is generated; the host supplies it.
  wire hdlc_tick = link_bit_tick & ~code_active_r;
  wire stuff_now = stuff_on_r & (ones_r == `HBR_STUFF_LIMIT);
  wire hdlc_bit = stuff_now ? 1'b0 : shift_r[0];
  wire byte_done = hdlc_tick & ~stuff_now & (bit_cnt_r == 4'd1);
  wire mid_packet = (state_r == HBR_TX_DATA) & ~cur_last_r;
  wire take_next = byte_done & txq.pop_valid;
  wire starve = byte_done & ~txq.pop_valid & mid_packet;

  assign txq.pop_ready = byte_done;

  always_comb
  begin
    state_nxt = state_r;
    if (take_next)
      state_nxt = HBR_TX_DATA;
    else if (starve)
      state_nxt = HBR_TX_ABORT;
    else if (byte_done)
      state_nxt = HBR_TX_FLAG;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= HBR_TX_FLAG;
      shift_r <= `HBR_FLAG_BYTE;
      bit_cnt_r <= `HBR_BYTE_BITS;
      stuff_on_r <= 1'b0;
      cur_last_r <= 1'b0;
    end
    else if (byte_done)
    begin
      state_r <= state_nxt;
      bit_cnt_r <= `HBR_BYTE_BITS;
      stuff_on_r <= take_next;
      cur_last_r <= take_next & txq.pop_data[`HBR_ENTRY_LAST];
      if (take_next)
        shift_r <= txq.pop_data[7:0];
      else if (starve)
        shift_r <= `HBR_ABORT_BYTE;
      else
        shift_r <= `HBR_FLAG_BYTE;
    end
    else if (hdlc_tick && !stuff_now)
    begin
      shift_r <= {1'b0, shift_r[7:1]};
      bit_cnt_r <= bit_cnt_r - 4'd1;
    end
  end

  // Ones run counter for zero insertion
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ones_r <= 3'd0;
    else if (hdlc_tick)
    begin
      if (stuff_now || !hdlc_bit)
        ones_r <= 3'd0;
      else
        ones_r <= ones_r + 3'd1;
    end
  end

  // ========================================================================
  // Code sender
  wire code_bit = code_word[code_idx_r];
  wire code_wrap = code_idx_r == `HBR_CODE_LAST_IDX;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      code_active_r <= 1'b0;
      code_idx_r <= 3'd0;
    end
    else if (code_rise)
    begin
      code_active_r <= 1'b1;
      code_idx_r <= 3'd0;
    end
    else if (!code_trig)
      code_active_r <= 1'b0;
    else if (code_active_r && link_bit_tick)
      code_idx_r <= code_wrap ? 3'd0 : code_idx_r + 3'd1;
  end

  // ========================================================================
  // Line source select
  wire onboard_bit = code_active_r ? code_bit : hdlc_bit;
  wire line_bit = onboard_link_source_select ? onboard_bit
                                             : ext_sync_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      link_out_r <= 1'b1;
    else if (link_bit_tick)
      link_out_r <= line_bit;
  end

  assign data_link_out = link_out_r;

  // ========================================================================
  // Underrun flag: a starve event in the clearing read cycle survives
  always_comb
  begin
    starved_nxt = starved_r;
    if (rd_tx_stat)
      starved_nxt = 1'b0;
    if (starve)
      starved_nxt = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      starved_r <= 1'b0;
    else
      starved_r <= starved_nxt;
  end

  // ========================================================================
  // Interrupt status, cleared by reading it; set wins over clear
  wire vacant_rise = txq.empty & ~vacant_d_r;
  wire rx_push = rxq.push_valid & rxq.push_ready;
  hbr_irq_t irq_set;

  always_comb
  begin
    irq_set = `HBR_IRQ_RST;
    irq_set[`HBR_IRQ_STARVED] = starve;
    irq_set[`HBR_IRQ_RX_DATA] = rx_push;
    irq_set[`HBR_IRQ_TX_VACANT] = vacant_rise;
    irq_stat_nxt = rd_irq_stat ? irq_set : (irq_stat_r | irq_set);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_stat_r <= `HBR_IRQ_RST;
      vacant_d_r <= 1'b1;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      vacant_d_r <= txq.empty;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

endmodule : hbr_top

`default_nettype wire

// ==== bench/hbr_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hbr_defs.svh"

module hbr_top_asserts
  import hbr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic rx_byte_valid,
  input wire hbr_pkg::hbr_byte_t rx_byte,
  input wire logic rx_byte_ready,
  input wire logic link_bit_tick,
  input wire logic external_link_data_input,
  input wire logic data_link_out,
  input wire logic irq
);
  // ==========================================================
  // Shadow of the bus-visible state
  logic ap_wr_r;
  logic [7:0] ap_idx_r;
  logic [7:0] ctl_r;
  logic [2:0] mask_r;
  logic [6:0] rx_cnt_r;
  logic [2:0] pos_r;
  logic [2:0] ext_r;
  wire take = hsel && hready && htrans[1];
  wire [7:0] idx = haddr[9:2];
  wire rd_take = take && !hwrite;
  wire rx_pop = rd_take && idx == `HBR_IDX_RX_DATA && rx_cnt_r != 7'h00;
  wire rx_push = rx_byte_valid && rx_byte_ready;
  wire ctl_wr = ap_wr_r && ap_idx_r == `HBR_IDX_CODE_CTRL;
  wire trig_rise = ctl_wr && hwdata[7] && !ctl_r[7];
  wire code_bit = ctl_r[pos_r];
  wire ext_steady = ext_r == {3{external_link_data_input}};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_wr_r <= 1'b0;
      ap_idx_r <= 8'h00;
      ctl_r <= 8'h00;
      mask_r <= 3'h0;
      rx_cnt_r <= 7'h00;
      pos_r <= 3'h0;
      ext_r <= 3'h0;
    end
    else
    begin
      ap_wr_r <= take && hwrite;
      ap_idx_r <= idx;
      ext_r <= {ext_r[1:0], external_link_data_input};
      rx_cnt_r <= rx_cnt_r + {6'h00, rx_push} - {6'h00, rx_pop};
      if (ctl_wr) ctl_r <= hwdata[7:0];
      if (ap_wr_r && ap_idx_r == `HBR_IDX_IRQ_MASK) mask_r <= hwdata[2:0];
      // Phase restarts only on a 0->1 of the trigger
      if (trig_rise) pos_r <= 3'h0;
      else if (link_bit_tick) pos_r <= (pos_r == `HBR_CODE_LAST_IDX) ?
        3'h0 : pos_r + 3'h1;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // Assertions
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_UPPER_ZERO: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_READ_HOLDS: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_RX_READY: assert property (rx_byte_ready == (rx_cnt_r != 7'h40))
    else $error("receive ready disagrees with fill");
  AST_RSVD_ZERO: assert property (rd_take && idx == `HBR_IDX_TX_STAT
    |=> hrdata[7:3] == 5'h00) else $error("status spare bits set");
  AST_IRQ_MASKED: assert property (irq |-> mask_r != 3'h0)
    else $error("interrupt with all sources masked");
  AST_RESET_IDLE: assert property ($rose(hresetn) |-> !irq && data_link_out)
    else $error("outputs not idle after reset");
  AST_EXT_PATH: assert property (!ctl_r[6] && !ctl_wr && link_bit_tick
    && ext_steady |=> data_link_out == $past(external_link_data_input))
    else $error("link not fed from pin");
  AST_CODE_BIT: assert property (ctl_r[7] && ctl_r[6] && !ctl_wr
    && link_bit_tick |=> data_link_out == $past(code_bit))
    else $error("code bit out of order");

  COV_TRIGGER: cover property (trig_rise);
  COV_IRQ: cover property (irq);
  COV_RX_FULL: cover property (!rx_byte_ready);
endmodule : hbr_top_asserts

`default_nettype wire

// ==== bench/hbr_host.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host processor model: single whole-word transfers
module hbr_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output var logic hsel,
  output var logic [31:0] haddr,
  output var logic [1:0] htrans,
  output var logic hwrite,
  output var logic [2:0] hsize,
  output var logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end

  task automatic xfer(input logic w, input logic [7:0] idx,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : hbr_host

`default_nettype wire

// ==== bench/tb_hbr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hbr_defs.svh"

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  n_fail++; $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
  end end

module tb_hbr_top;
  import hbr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic rx_byte_valid, rx_byte_ready, link_bit_tick;
  logic external_link_data_input, data_link_out, found;
  logic tick_d = 1'b0;
  logic seen_abort = 1'b0;
  hbr_byte_t rx_byte;
  logic [63:0] bits = 64'h0;
  int n_fail, cmp_count, cyc, nb, run;
  localparam logic [5:0] CODE = 6'h2D;

  hbr_top hbr_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
    .rx_byte_valid, .rx_byte, .rx_byte_ready, .link_bit_tick,
    .external_link_data_input, .data_link_out, .irq);
  hbr_host hbr_host_inst (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata);

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ==========================================================
  // Link monitor: one bit per tick, current run of ones
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      final_report();
    end
    else
    begin
      tick_d <= link_bit_tick;
      // Bit count restarts while the link is stalled, one writer only
      if (!tick_d)
        nb <= 0;
      else
      begin
        bits[nb[5:0]] <= data_link_out;
        nb <= nb + 1;
        run <= data_link_out ? run + 1 : 0;
        if (run >= 7 && data_link_out) seen_abort <= 1'b1;
      end
    end
  end

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    hbr_host_inst.xfer(1'b1, idx, {24'h000000, d}, v);
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    hbr_host_inst.xfer(1'b0, idx, 32'h00000000, v);
  endtask : rd

  task automatic push(input hbr_byte_t b);
    @(posedge hclk);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    do @(posedge hclk); while (rx_byte_ready !== 1'b1);
    rx_byte_valid <= 1'b0;
  endtask : push

  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // ==========================================================
  // Main sequence
  initial
  begin
    hresetn = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    link_bit_tick = 1'b0;
    external_link_data_input = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`HBR_IDX_CODE_CTRL); `CHK(v, 32'h00000000)
    rd(`HBR_IDX_TX_STAT); `CHK(v, 32'h00000004)
    rd(8'h20); `CHK(v, 32'h00000000)
    for (int i = 0; i < 64; i++) push(8'(i) ^ 8'hA5);
    #1 `CHK(rx_byte_ready, 1'b0)
    `CHK(irq, 1'b0)
    for (int i = 0; i < 64; i++)
    begin
      rd(`HBR_IDX_RX_DATA); `CHK(v, {24'h000000, 8'(i) ^ 8'hA5})
    end
    rd(`HBR_IDX_RX_DATA); `CHK(v, 32'h00000000)
    // Fill with the link stalled, then let it run dry mid-packet
    wr(`HBR_IDX_CODE_CTRL, 8'h40);
    for (int i = 0; i < 64; i++) wr(`HBR_IDX_TX_DATA, 8'(i));
    rd(`HBR_IDX_TX_STAT); `CHK(v, 32'h00000002)
    wr(`HBR_IDX_IRQ_MASK, 8'h01);
    link_bit_tick <= 1'b1;
    v = 32'h0;
    for (int k = 0; k < 3000 && v[0] !== 1'b1; k++)
      rd(`HBR_IDX_TX_STAT);
    `CHK(v, 32'h00000005)
    `CHK(irq, 1'b1)
    rd(`HBR_IDX_TX_STAT); `CHK(v, 32'h00000004)
    // Underrun, receive arrival and transmit drain have all fired
    rd(`HBR_IDX_IRQ_STAT); `CHK(v, 32'h00000007)
    `CHK(irq, 1'b0)
    // Abort byte may still be on the wire at this point
    for (int k = 0; k < 40 && seen_abort !== 1'b1; k++) @(posedge hclk);
    `CHK(seen_abort, 1'b1)
    wr(`HBR_IDX_CODE_CTRL, 8'h00);
    external_link_data_input <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK(data_link_out, 1'b1)
    external_link_data_input <= 1'b0;
    repeat (8) @(posedge hclk);
    `CHK(data_link_out, 1'b0)
    // Code start with the link stalled, so phase is known
    link_bit_tick <= 1'b0;
    wr(`HBR_IDX_CODE_CTRL, {2'h1, CODE});
    wr(`HBR_IDX_CODE_CTRL, {2'h3, CODE});
    link_bit_tick <= 1'b1;
    for (int k = 0; k < 100 && nb < 12; k++) @(posedge hclk);
    `CHK(bits[11:0], {CODE, CODE})
    // Code has no run of six ones, so a flag proves HDLC is back
    link_bit_tick <= 1'b0;
    wr(`HBR_IDX_CODE_CTRL, {2'h1, CODE});
    link_bit_tick <= 1'b1;
    for (int k = 0; k < 100 && nb < 32; k++) @(posedge hclk);
    found = 1'b0;
    for (int i = 0; i < 25; i++) if (bits[i +: 8] == 8'h7E) found = 1'b1;
    `CHK(found, 1'b1)
    // A packet closed by its last byte must not count as underrun
    link_bit_tick <= 1'b0;
    wr(`HBR_IDX_TX_DATA, 8'h11);
    wr(`HBR_IDX_TX_END, 8'h22);
    link_bit_tick <= 1'b1;
    repeat (60) @(posedge hclk);
    rd(`HBR_IDX_TX_STAT); `CHK(v, 32'h00000004)
    `CHK(irq, 1'b0)
    final_report();
  end
endmodule : tb_hbr_top

bind hbr_top hbr_top_asserts hbr_top_asserts_inst (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
  .hrdata, .rx_byte_valid, .rx_byte, .rx_byte_ready, .link_bit_tick,
  .external_link_data_input, .data_link_out, .irq);

`default_nettype wire
